//--- common/acs_pkg.sv
// Shared constants and types for the ADC conversion sequencer
package acs_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Sizes and clocking
  localparam int SYS_CLK_NS = 40;
  localparam int RES_W = 12;
  localparam int CTRL_W = 8;
  localparam int NUM_IN = 6;
  localparam int PIN_W = 12;
  localparam int DIV_W = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // Power/clock field codes
  localparam logic [1:0] PCS_FULL_PD = 2'h0;
  localparam logic [1:0] PCS_STANDBY = 2'h1;
  localparam logic [1:0] PCS_NORM_INT = 2'h2;
  localparam logic [1:0] PCS_NORM_EXT = 2'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // Sequence timing, in conversion-clock falling edges
  localparam logic [2:0] ACQ_EDGES = 3'h4;
  localparam logic [2:0] ACQ_LAST = ACQ_EDGES - 3'h1;
  localparam logic [3:0] CONV_CYCLES = 4'hD;
  localparam logic [3:0] CONV_LAST = CONV_CYCLES - 4'h1;

  // Internal oscillator: whole conversion in about this many ns
  localparam int INT_CONV_NS = 3600;
  localparam int INT_CLK_DIV = INT_CONV_NS / (13 * SYS_CLK_NS);
  localparam logic [DIV_W-1:0] INT_DIV_LAST = DIV_W'(INT_CLK_DIV - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'hC0;
  localparam logic CLK_EXT_RST = 1'b1;
  localparam logic [PIN_W-1:0] PINS_RST = 12'hE00;
  localparam logic [RES_W-1:0] SAR_FIRST = 12'h800;

  ////////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic power_clock_sel_hi;
    logic power_clock_sel_lo;
    logic acq_timing_bit;
    logic input_pairing_bit;
    logic polarity_bit;
    logic chan_sel_2;
    logic chan_sel_1;
    logic chan_sel_0;
  } acs_ctrl_t;

  typedef struct packed {
    logic [NUM_IN-1:0] pos_sel;
    logic [NUM_IN-1:0] neg_sel;
    logic neg_com;
  } acs_mux_t;

  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic conv_clk;
    logic [CTRL_W-1:0] data;
  } acs_pins_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACQ_INT,
    ST_ACQ_EXT,
    ST_CONV
  } acs_state_t;

endpackage

//--- core/acs_pin_sync.sv
// Three-stage pin synchroniser; a bit changes once stages two and three agree
`timescale 1ns/1ps
module acs_pin_sync #(
  parameter int W = 12,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } acs_sync_st_t;

  localparam acs_sync_st_t SYNC_RST = {RST_VAL, RST_VAL, RST_VAL, RST_VAL};

  acs_sync_st_t st_r;
  acs_sync_st_t st_nxt;

  // Stage one feeds stage two only, to keep metastability off any logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.q = (st_r.s2 & ~(st_r.s2 ^ st_r.s3)) | (st_r.q & (st_r.s2 ^ st_r.s3));
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_r <= SYNC_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level = st_r.q;

endmodule // acs_pin_sync

//--- core/acs_mux_decode.sv
// Input multiplexer decode from the control byte
`timescale 1ns/1ps
module acs_mux_decode #(
  parameter int NUM_CH = acs_pkg::NUM_IN
) (
  input acs_pkg::acs_ctrl_t ctrl,
  output acs_pkg::acs_mux_t mux
);

  function automatic logic [acs_pkg::NUM_IN-1:0] onehot(
    input logic [2:0] idx,
    input logic ok
  );
    onehot = ok ? (6'h01 << idx) : 6'h00;
  endfunction

  logic [2:0] code;
  logic valid;

  assign code = {ctrl.chan_sel_2, ctrl.chan_sel_1, ctrl.chan_sel_0};
  // Codes 110 and 111, and codes past a smaller variant, leave every switch open
  assign valid = code < 3'(NUM_CH);

  always_comb begin
    if (ctrl.input_pairing_bit) begin
      mux.pos_sel = onehot(code, valid);
      mux.neg_sel = 6'h00;
      mux.neg_com = valid;
    end else begin
      // Even code: lower input positive; odd code: upper input positive
      mux.pos_sel = onehot(code, valid);
      mux.neg_sel = onehot(code ^ 3'h1, valid);
      mux.neg_com = 1'b0;
    end
  end

endmodule // acs_mux_decode

//--- core/acs_core.sv
// Conversion sequencer: control byte, track/hold timing, SAR and result port
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Single-ended codes 0-5 pick input, common negative
// - Pseudo-differential pairs adjacent inputs, parity picks polarity
// - Tracking starts on write strobe rising edge
// - External acquisition holds on next write edge
// - Internal acquisition holds on fourth falling clock
// - Conversion always takes 13 conversion clocks
// - Write during conversion aborts, restarts acquisition
// - Acquisition bit clear: timed acquisition, auto conversion
// - Acquisition bit set: acquire until next write
// - Second write, bit clear, ends acquisition, converts
// - Completion flag drops low when result ready
// - Flag rises on first read or new write
// - Top two bits pick clock; power-down keeps it
// - External conversion clock used after reset
// - Code 10 selects normal, internal oscillator
// - Code 11 selects normal, external clock
// - Either acquisition mode works with either clock
// - One tri-state bus carries control and result
// - Control byte captured from data lines 7-0
// - Chip select high ignores strobes, clock; bus floats
// - Result straight binary unipolar, two's complement bipolar
// - Codes 00/01 power down; 10/11 normal
`timescale 1ns/1ps
module acs_core (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic conv_clk_pin,
  input wire logic [acs_pkg::CTRL_W-1:0] bus_wr_data,
  output logic [acs_pkg::RES_W-1:0] bus_rd_data,
  output logic bus_drive,
  input wire logic comp_hi,
  output logic [acs_pkg::RES_W-1:0] sar_trial,
  output logic track_en,
  output acs_pkg::acs_mux_t mux_sel,
  output logic polarity_bit,
  output logic done_n,
  output logic clk_int_sel,
  output logic pd_full,
  output logic pd_standby,
  output logic [1:0] seq_state
);

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    acs_pkg::acs_state_t state;
    acs_pkg::acs_ctrl_t ctrl;
    acs_pkg::acs_mux_t mux;
    logic clk_ext;
    logic track;
    logic done_n;
    logic wr_d;
    logic rd_d;
    logic clk_d;
    logic [2:0] acq_cnt;
    logic [3:0] conv_cnt;
    logic [acs_pkg::DIV_W-1:0] div_cnt;
    logic [acs_pkg::RES_W-1:0] sar;
    logic [acs_pkg::RES_W-1:0] result;
    logic pd_full;
    logic pd_standby;
  } acs_core_st_t;

  localparam acs_core_st_t CORE_RST = '{
    state: acs_pkg::ST_IDLE,
    ctrl: acs_pkg::CTRL_RST,
    mux: '0,
    clk_ext: acs_pkg::CLK_EXT_RST,
    track: 1'b0,
    done_n: 1'b1,
    wr_d: 1'b1,
    rd_d: 1'b1,
    clk_d: 1'b0,
    acq_cnt: 3'h0,
    conv_cnt: 4'h0,
    div_cnt: '0,
    sar: '0,
    result: '0,
    pd_full: 1'b0,
    pd_standby: 1'b0
  };

  acs_core_st_t st_r;
  acs_core_st_t st_nxt;

  acs_pkg::acs_pins_t pins_raw;
  acs_pkg::acs_pins_t pins;
  acs_pkg::acs_ctrl_t ctrl_w;
  acs_pkg::acs_mux_t mux_w;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and multiplexer decode

  assign pins_raw.cs_n = cs_n;
  assign pins_raw.wr_n = wr_n;
  assign pins_raw.rd_n = rd_n;
  assign pins_raw.conv_clk = conv_clk_pin;
  assign pins_raw.data = bus_wr_data;

  // Data lines go through the same stages as the strobe, so they line up at the edge
  acs_pin_sync #(
    .W(acs_pkg::PIN_W),
    .RST_VAL(acs_pkg::PINS_RST)
  ) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .pin(pins_raw),
    .level(pins)
  );

  assign ctrl_w = acs_pkg::acs_ctrl_t'(pins.data);

  acs_mux_decode #(
    .NUM_CH(acs_pkg::NUM_IN)
  ) u_mux (
    .ctrl(ctrl_w),
    .mux(mux_w)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Bipolar result is the offset-binary code with its top bit turned over
  function automatic logic [acs_pkg::RES_W-1:0] fmt_result(
    input logic [acs_pkg::RES_W-1:0] code,
    input logic unipolar
  );
    fmt_result = unipolar ? code : (code ^ acs_pkg::SAR_FIRST);
  endfunction

  function automatic logic [1:0] pcs_of(input acs_pkg::acs_ctrl_t c);
    pcs_of = {c.power_clock_sel_hi, c.power_clock_sel_lo};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    logic selected;
    logic wr_rise;
    logic rd_fall;
    logic ext_fall;
    logic int_tick;
    logic tick;
    logic [acs_pkg::RES_W-1:0] mask;
    logic [acs_pkg::RES_W-1:0] sar_step;
    selected = 1'b0;
    wr_rise = 1'b0;
    rd_fall = 1'b0;
    ext_fall = 1'b0;
    int_tick = 1'b0;
    tick = 1'b0;
    mask = '0;
    sar_step = '0;

    st_nxt = st_r;
    st_nxt.wr_d = pins.wr_n;
    st_nxt.rd_d = pins.rd_n;
    st_nxt.clk_d = pins.conv_clk;

    // Strobes and the external clock count only while selected
    selected = !pins.cs_n;
    wr_rise = selected && !st_r.wr_d && pins.wr_n;
    rd_fall = selected && st_r.rd_d && !pins.rd_n;
    ext_fall = selected && st_r.clk_d && !pins.conv_clk;

    // Internal oscillator: a falling-edge event every few system clocks
    if (st_r.clk_ext) begin
      st_nxt.div_cnt = '0;
    end else if (st_r.div_cnt == acs_pkg::INT_DIV_LAST) begin
      st_nxt.div_cnt = '0;
      int_tick = 1'b1;
    end else begin
      st_nxt.div_cnt = st_r.div_cnt + 1'b1;
    end

    // Same sequence whichever clock is chosen
    tick = st_r.clk_ext ? ext_fall : int_tick;

    // SAR trial step: settle the current bit, try the next one down
    mask = acs_pkg::SAR_FIRST >> st_r.conv_cnt;
    sar_step = comp_hi ? st_r.sar : (st_r.sar & ~mask);
    sar_step = sar_step | (mask >> 1);

    // A read cycle clears the flag; a completion below overrides it
    if (rd_fall) begin
      st_nxt.done_n = 1'b1;
    end

    if (wr_rise) begin
      st_nxt.ctrl = ctrl_w;
      st_nxt.mux = mux_w;
      st_nxt.done_n = 1'b1;
      // Power-down codes leave the clock source alone
      case (pcs_of(ctrl_w))
        acs_pkg::PCS_NORM_INT: st_nxt.clk_ext = 1'b0;
        acs_pkg::PCS_NORM_EXT: st_nxt.clk_ext = 1'b1;
        default: st_nxt.clk_ext = st_r.clk_ext;
      endcase
      st_nxt.acq_cnt = 3'h0;
      st_nxt.conv_cnt = 4'h0;
      // Any write, even mid-conversion, restarts the sequence, except a bit-clear write during external acquisition, which converts
      if (st_r.state == acs_pkg::ST_ACQ_EXT && !ctrl_w.acq_timing_bit) begin
        st_nxt.state = acs_pkg::ST_CONV;
        st_nxt.track = 1'b0;
        st_nxt.sar = acs_pkg::SAR_FIRST;
      end else if (ctrl_w.acq_timing_bit) begin
        st_nxt.state = acs_pkg::ST_ACQ_EXT;
        st_nxt.track = 1'b1;
      end else begin
        st_nxt.state = acs_pkg::ST_ACQ_INT;
        st_nxt.track = 1'b1;
      end
    end else begin
      case (st_r.state)
        acs_pkg::ST_IDLE: begin
          st_nxt.track = 1'b0;
        end
        acs_pkg::ST_ACQ_INT: begin
          if (tick) begin
            if (st_r.acq_cnt == acs_pkg::ACQ_LAST) begin
              st_nxt.state = acs_pkg::ST_CONV;
              st_nxt.track = 1'b0;
              st_nxt.conv_cnt = 4'h0;
              st_nxt.sar = acs_pkg::SAR_FIRST;
            end else begin
              st_nxt.acq_cnt = st_r.acq_cnt + 3'h1;
            end
          end
        end
        acs_pkg::ST_ACQ_EXT: begin
          // Holds here until the next write, however long that takes
          st_nxt.track = 1'b1;
        end
        acs_pkg::ST_CONV: begin
          if (tick) begin
            if (st_r.conv_cnt == acs_pkg::CONV_LAST) begin
              st_nxt.state = acs_pkg::ST_IDLE;
              st_nxt.result = fmt_result(st_r.sar, st_r.ctrl.polarity_bit);
              st_nxt.done_n = 1'b0;
            end else begin
              st_nxt.sar = sar_step;
              st_nxt.conv_cnt = st_r.conv_cnt + 4'h1;
            end
          end
        end
        default: begin
          st_nxt.state = acs_pkg::ST_IDLE;
          st_nxt.track = 1'b0;
        end
      endcase
    end

    // Power-down applies once the sequence, dummy or real, has finished
    st_nxt.pd_full = (st_nxt.state == acs_pkg::ST_IDLE)
      && (pcs_of(st_nxt.ctrl) == acs_pkg::PCS_FULL_PD);
    st_nxt.pd_standby = (st_nxt.state == acs_pkg::ST_IDLE)
      && (pcs_of(st_nxt.ctrl) == acs_pkg::PCS_STANDBY);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_r <= CORE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Result stays put during a conversion; a read mid-conversion sees the last one
  assign bus_rd_data = st_r.result;
  assign bus_drive = !pins.cs_n && !pins.rd_n;
  assign sar_trial = st_r.sar;
  assign track_en = st_r.track;
  assign mux_sel = st_r.mux;
  assign polarity_bit = st_r.ctrl.polarity_bit;
  assign done_n = st_r.done_n;
  assign clk_int_sel = !st_r.clk_ext;
  assign pd_full = st_r.pd_full;
  assign pd_standby = st_r.pd_standby;
  assign seq_state = st_r.state;

endmodule // acs_core

//--- testbench/acs_props.sv
// Port-level checks on the conversion sequencer
`timescale 1ns/1ps
module acs_props (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic bus_drive,
  input wire logic track_en,
  input acs_pkg::acs_mux_t mux_sel,
  input wire logic done_n,
  input wire logic clk_int_sel,
  input wire logic pd_full,
  input wire logic pd_standby,
  input wire logic [1:0] seq_state
);
  // Cycles since a selected strobe was low; saturates so old strobes never count
  logic [3:0] wr_age_r;
  logic [3:0] rd_age_r;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_age_r <= 4'hF;
      rd_age_r <= 4'hF;
    end else begin
      wr_age_r <= (!wr_n && !cs_n) ? 4'h0 : wr_age_r + {3'h0, wr_age_r != 4'hF};
      rd_age_r <= (!rd_n && !cs_n) ? 4'h0 : rd_age_r + {3'h0, rd_age_r != 4'hF};
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////////
  property p_drv_cause;
    $rose(bus_drive) |-> !$past(rd_n, 2) && !$past(cs_n, 2);
  endproperty
  a_drv_cause: assert property (p_drv_cause) else $error("bus driven without read");
  property p_drv_rd_off;
    $rose(rd_n) |-> ##[1:6] !bus_drive;
  endproperty
  a_drv_rd_off: assert property (p_drv_rd_off) else $error("bus held after read");
  property p_drv_cs_off;
    $rose(cs_n) |-> ##[1:6] !bus_drive;
  endproperty
  a_drv_cs_off: assert property (p_drv_cs_off) else $error("bus held after deselect");
  property p_done_fall;
    $fell(done_n) |-> $past(seq_state) == 2'h3;
  endproperty
  a_done_fall: assert property (p_done_fall) else $error("flag set outside conversion");
  property p_done_rise;
    $rose(done_n) |-> rd_age_r < 4'hC || wr_age_r < 4'hC;
  endproperty
  a_done_rise: assert property (p_done_rise) else $error("flag cleared without access");
  property p_track_state;
    track_en |-> seq_state == 2'h1 || seq_state == 2'h2;
  endproperty
  a_track_state: assert property (p_track_state) else $error("tracking outside acquire");
  property p_ext_hold;
    $fell(track_en) && $past(seq_state) == 2'h2 |-> wr_age_r < 4'hC;
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("external hold without write");
  property p_clk_keep;
    $changed(clk_int_sel) |-> wr_age_r < 4'hC;
  endproperty
  a_clk_keep: assert property (p_clk_keep) else $error("clock source changed alone");
  property p_mux_shape;
    $onehot0(mux_sel.pos_sel) && $onehot0(mux_sel.neg_sel) && !(mux_sel.neg_com && |mux_sel.neg_sel);
  endproperty
  a_mux_shape: assert property (p_mux_shape) else $error("bad mux selection");
  property p_pd_idle;
    pd_full || pd_standby |-> seq_state == 2'h0 && !(pd_full && pd_standby);
  endproperty
  a_pd_idle: assert property (p_pd_idle) else $error("power-down while busy");
  c_read: cover property ($rose(bus_drive));
  c_ext: cover property (seq_state == 2'h2 ##1 seq_state == 2'h3);
  c_pd: cover property ($rose(pd_full));
endmodule // acs_props
bind acs_core acs_props acs_props_inst (.clk_sys(clk_sys), .resetn(resetn), .cs_n(cs_n),
  .wr_n(wr_n), .rd_n(rd_n), .bus_drive(bus_drive), .track_en(track_en), .mux_sel(mux_sel),
  .done_n(done_n), .clk_int_sel(clk_int_sel), .pd_full(pd_full), .pd_standby(pd_standby),
  .seq_state(seq_state));

//--- testbench/acs_host_model.sv
// Host processor model: select, strobes, data bus and conversion clock
`timescale 1ns/1ps
module acs_host_model (
  input wire logic clk_sys,
  input wire logic [11:0] rd_bus,
  input wire logic rd_drive,
  output logic cs_n,
  output logic wr_n,
  output logic rd_n,
  output logic conv_clk,
  output logic [7:0] data
);
  initial begin
    cs_n = 1'b0;
    wr_n = 1'b1;
    rd_n = 1'b1;
    conv_clk = 1'b0;
    data = 8'h00;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Byte held past the synchroniser, then the bus is let go (inverse shown)
  task automatic write_byte(input logic [7:0] b, input logic sel);
    @(negedge clk_sys);
    cs_n = !sel;
    data = b;
    wait_clk(1);
    wr_n = 1'b0;
    wait_clk(5);
    wr_n = 1'b1;
    wait_clk(6);
    data = ~b;
    cs_n = 1'b0;
  endtask
  task automatic read_word(input logic sel, output logic [11:0] v, output logic drv);
    @(negedge clk_sys);
    cs_n = !sel;
    rd_n = 1'b0;
    wait_clk(6);
    v = rd_bus;
    drv = rd_drive;
    rd_n = 1'b1;
    cs_n = 1'b0;
    wait_clk(6);
  endtask
  // About 2.5 MHz, 40 percent high; clock rests low between bursts
  task automatic conv_edges(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      conv_clk = 1'b1;
      wait_clk(4);
      conv_clk = 1'b0;
      wait_clk(5);
    end
  endtask
endmodule // acs_host_model

//--- testbench/testbench.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module testbench;
  // Analog level seen by the ideal comparator; scenarios move it
  logic [11:0] ain = 12'hA5C;
  logic clk_sys, resetn, cs_n, wr_n, rd_n, conv_clk, bus_drive, comp_hi, track_en;
  logic polarity_bit, done_n, clk_int_sel, pd_full, pd_standby, drv;
  logic [7:0] data;
  logic [11:0] bus_rd_data, sar_trial, v;
  logic [1:0] seq_state;
  acs_pkg::acs_mux_t mux_sel;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  // Ideal comparator on the input level the scenario sets
  assign comp_hi = sar_trial <= ain;
  acs_core acs_core_inst (.clk_sys(clk_sys), .resetn(resetn), .cs_n(cs_n), .wr_n(wr_n),
    .rd_n(rd_n), .conv_clk_pin(conv_clk), .bus_wr_data(data), .bus_rd_data(bus_rd_data),
    .bus_drive(bus_drive), .comp_hi(comp_hi), .sar_trial(sar_trial), .track_en(track_en),
    .mux_sel(mux_sel), .polarity_bit(polarity_bit), .done_n(done_n),
    .clk_int_sel(clk_int_sel), .pd_full(pd_full), .pd_standby(pd_standby),
    .seq_state(seq_state));
  acs_host_model acs_host_model_inst (.clk_sys(clk_sys), .rd_bus(bus_rd_data),
    .rd_drive(bus_drive), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .conv_clk(conv_clk),
    .data(data));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (done_n !== 1'b0 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    check("done_n", done_n, 16'h0);
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_int_acq();
    acs_host_model_inst.write_byte(8'hDA, 1'b1);
    check("seq", seq_state, 16'h1);
    check("track", track_en, 16'h1);
    check("mux", mux_sel, {3'h0, 6'h04, 6'h00, 1'b1});
    check("polarity", polarity_bit, 16'h1);
    acs_host_model_inst.conv_edges(3);
    check("track", track_en, 16'h1);
    acs_host_model_inst.conv_edges(1);
    check("seq", {track_en, seq_state}, 16'h3);
    acs_host_model_inst.conv_edges(12);
    check("done_n", done_n, 16'h1);
    acs_host_model_inst.conv_edges(1);
    check("done_n", done_n, 16'h0);
    acs_host_model_inst.read_word(1'b1, v, drv);
    check("result", {drv, v}, {3'h0, 1'b1, ain});
    check("done_n", {bus_drive, done_n}, 16'h1);
    $display("internal acquisition test done");
  endtask
  task automatic t_abort();
    acs_host_model_inst.write_byte(8'hDA, 1'b1);
    acs_host_model_inst.conv_edges(8);
    check("seq", seq_state, 16'h3);
    acs_host_model_inst.write_byte(8'hD9, 1'b1);
    check("seq", {track_en, seq_state}, 16'h5);
    check("mux", mux_sel, {3'h0, 6'h02, 6'h00, 1'b1});
    acs_host_model_inst.conv_edges(17);
    wait_done();
    acs_host_model_inst.read_word(1'b1, v, drv);
    $display("abort test done");
  endtask
  task automatic t_ext_acq();
    int n;
    ain = 12'h3C1;
    acs_host_model_inst.write_byte(8'hA3, 1'b1);
    check("int clk", clk_int_sel, 16'h1);
    check("polarity", polarity_bit, 16'h0);
    check("mux", mux_sel, {3'h0, 6'h08, 6'h04, 1'b0});
    acs_host_model_inst.wait_clk(60);
    check("seq", {track_en, seq_state}, 16'h6);
    acs_host_model_inst.write_byte(8'h83, 1'b1);
    check("seq", {track_en, seq_state}, 16'h3);
    n = 0;
    while (done_n !== 1'b0 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    check("conv time", n >= 68 && n <= 84, 16'h1);
    acs_host_model_inst.read_word(1'b1, v, drv);
    check("result", v, {~ain[11], ain[10:0]});
    $display("external acquisition test done");
  endtask
  task automatic t_power();
    acs_host_model_inst.write_byte(8'h1A, 1'b1);
    check("int clk", clk_int_sel, 16'h1);
    wait_done();
    check("pd", {pd_full, pd_standby}, 16'h2);
    acs_host_model_inst.read_word(1'b1, v, drv);
    acs_host_model_inst.write_byte(8'h5A, 1'b1);
    wait_done();
    check("pd", {clk_int_sel, pd_full, pd_standby}, 16'h5);
    acs_host_model_inst.read_word(1'b1, v, drv);
    $display("power-down test done");
  endtask
  task automatic t_select();
    acs_host_model_inst.write_byte(8'hDE, 1'b1);
    check("mux", {mux_sel, clk_int_sel}, 16'h0);
    acs_host_model_inst.write_byte(8'hDD, 1'b0);
    check("seq", {mux_sel, seq_state}, 16'h1);
    acs_host_model_inst.read_word(1'b0, v, drv);
    check("drive", drv, 16'h0);
    acs_host_model_inst.conv_edges(17);
    wait_done();
    acs_host_model_inst.read_word(1'b1, v, drv);
    $display("select test done");
  endtask
  initial begin
    resetn = 1'b0;
    repeat (8) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (2) @(negedge clk_sys);
    check("reset", {done_n, clk_int_sel, seq_state, bus_drive}, 16'h10);
    t_int_acq();
    t_abort();
    t_ext_acq();
    t_power();
    t_select();
    complete_run();
  end
endmodule // testbench
